/* File: hw/asp_pkg.sv */
package asp_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [3:0] OVERSAMPLE = 4'hf + 4'h0;
  localparam logic [3:0] BIT_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [7:0] IDLE_TICKS_8 = 8'h10 * 8'(FRAME_BITS_8);
  localparam logic [7:0] IDLE_TICKS_9 = 8'h10 * 8'(FRAME_BITS_9);
  localparam logic [3:0] PRESC_DIV0 = 4'h1;
  localparam logic [3:0] PRESC_DIV1 = 4'h3;
  localparam logic [3:0] PRESC_DIV2 = 4'h4;
  localparam logic [3:0] PRESC_DIV3 = 4'hd;
  localparam logic [31:0] OFF_BAUD = 32'h0000_0000;
  localparam logic [31:0] OFF_CTRL1 = 32'h0000_0004;
  localparam logic [31:0] OFF_CTRL2 = 32'h0000_0008;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_000c;
  localparam logic [31:0] OFF_DATA = 32'h0000_0010;
  localparam int unsigned B_RATE = 0;
  localparam int unsigned B_PRESC = 4;
  localparam int unsigned C1_RX9 = 7;
  localparam int unsigned C1_TX9 = 6;
  localparam int unsigned C1_LEN9 = 4;
  localparam int unsigned C1_WAKE = 3;
  localparam int unsigned C2_TIE = 7;
  localparam int unsigned C2_TX_DONE_IRQ_EN = 6;
  localparam int unsigned C2_RIE = 5;
  localparam int unsigned C2_QUIET_LINE_IRQ_EN = 4;
  localparam int unsigned C2_TE = 3;
  localparam int unsigned C2_RE = 2;
  localparam int unsigned C2_RWU = 1;
  localparam int unsigned C2_SBK = 0;
  localparam int unsigned F_TX_EMPTY_FLAG = 7;
  localparam int unsigned F_TC = 6;
  localparam int unsigned F_RX_FULL_FLAG = 5;
  localparam int unsigned F_IDLE = 4;
  localparam int unsigned F_OVR = 3;
  localparam int unsigned F_NF = 2;
  localparam int unsigned F_FE = 1;
  localparam logic RST_TX_EMPTY_FLAG = 1'b1;
  localparam logic RST_TC = 1'b1;
  localparam logic RST_IDLE_ARMED = 1'b1;
  localparam logic RST_TXD = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TX_IDLE = 2'h0, TX_DATA = 2'h1, TX_PRE = 2'h3, TX_BRK = 2'h2
  } asp_tx_e;
  typedef enum logic [1:0] {
    RX_IDLE = 2'h0, RX_START = 2'h1, RX_BITS = 2'h3
  } asp_rx_e;
endpackage

/* File: hw/asp_top.sv */
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module asp_top
  import asp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe,
  output logic irq
);
  typedef struct packed {
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [7:0] wdata;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [1:0] presc;
    logic [2:0] rate;
    logic r8, t8, len9, wake;
    logic tx_empty_irq_en, tx_done_irq_en, rx_full_irq_en, quiet_line_irq_en, te, re, rx_sleep_bit, break_send;
    logic tx_empty_flag, tc, rx_full_flag, idle, ovr, nf, fe;
    logic [4:0] snap;
    logic tx_arm;
    logic [7:0] rx_hold;
    logic [7:0] tx_hold;
    logic [3:0] pcnt;
    logic [6:0] rcnt;
    asp_tx_e tst;
    logic te_d;
    logic [10:0] tshift;
    logic [3:0] tbit;
    logic [3:0] tsub;
    logic txd, txd_oe;
    asp_rx_e rxs;
    logic [3:0] rsub;
    logic [3:0] ridx;
    logic [8:0] rshift;
    logic [2:0] smp;
    logic rnoise;
    logic [7:0] ilc;
    logic idle_armed;
    logic irq;
  } asp_state_s;

  asp_state_s st_r;
  asp_state_s st_nxt;
  logic [3:0] presc_top;
  logic [6:0] rate_top;
  logic rt_tick;
  logic aw_go, w_go, wr_fire, rd_fire, cfg_wr;
  logic [31:0] wr_addr, rd_addr;
  logic [3:0] nbits, ndata;
  logic [7:0] idle_top;
  logic maj, nz;

  // divider chain: prescaler then power-of-two rate stage
  assign presc_top = (st_r.presc == 2'h0) ? PRESC_DIV0 - 4'h1 :
                     (st_r.presc == 2'h1) ? PRESC_DIV1 - 4'h1 :
                     (st_r.presc == 2'h2) ? PRESC_DIV2 - 4'h1 : PRESC_DIV3 - 4'h1;
  assign rate_top = 7'((8'h1 << st_r.rate) - 8'h1);
  assign rt_tick = (st_r.pcnt == presc_top) && (st_r.rcnt == rate_top);
  // bus handshakes and decoded addresses
  assign aw_go = s_axi_awvalid && st_r.awready;
  assign w_go = s_axi_wvalid && st_r.wready;
  assign wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
  assign rd_fire = s_axi_arvalid && st_r.arready;
  assign wr_addr = {st_r.awaddr[31:2], 2'h0};
  assign rd_addr = {s_axi_araddr[31:2], 2'h0};
  assign cfg_wr = wr_fire && st_r.wlane0 && (wr_addr == OFF_BAUD);
  // frame shape follows the length select
  assign nbits = st_r.len9 ? FRAME_BITS_9 : FRAME_BITS_8;
  assign ndata = st_r.len9 ? DATA_BITS_9 : DATA_BITS_8;
  assign idle_top = st_r.len9 ? IDLE_TICKS_9 : IDLE_TICKS_8;
  // majority of three mid-bit samples; any disagreement is noise
  assign maj = (st_r.smp[0] & st_r.smp[1]) | (st_r.smp[0] & st_r.smp[2]) |
               (st_r.smp[1] & st_r.smp[2]);
  assign nz = !((&st_r.smp) || !(|st_r.smp));

  // next state of the whole block
  always_comb begin
    asp_state_s s;
    logic idle_hit;
    s = st_r;
    idle_hit = 1'b0;
    // write channel capture, address and data in either order
    if (aw_go) begin
      s.aw_have = 1'b1;
      s.awaddr = s_axi_awaddr;
    end
    if (w_go) begin
      s.w_have = 1'b1;
      s.wdata = s_axi_wdata[7:0];
      s.wlane0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      s.bvalid = 1'b0;
    end
    if (wr_fire) begin
      s.aw_have = 1'b0;
      s.w_have = 1'b0;
      s.bvalid = 1'b1;
      s.bresp = RESP_OKAY;
      case (wr_addr)
        OFF_BAUD: if (st_r.wlane0) begin
          s.presc = st_r.wdata[B_PRESC +: 2];
          s.rate = st_r.wdata[B_RATE +: 3];
        end
        OFF_CTRL1: if (st_r.wlane0) begin
          s.t8 = st_r.wdata[C1_TX9];
          s.len9 = st_r.wdata[C1_LEN9];
          s.wake = st_r.wdata[C1_WAKE];
        end
        OFF_CTRL2: if (st_r.wlane0) begin
          s.tx_empty_irq_en = st_r.wdata[C2_TIE];
          s.tx_done_irq_en = st_r.wdata[C2_TX_DONE_IRQ_EN];
          s.rx_full_irq_en = st_r.wdata[C2_RIE];
          s.quiet_line_irq_en = st_r.wdata[C2_QUIET_LINE_IRQ_EN];
          s.te = st_r.wdata[C2_TE];
          s.re = st_r.wdata[C2_RE];
          s.rx_sleep_bit = st_r.wdata[C2_RWU];
          s.break_send = st_r.wdata[C2_SBK];
        end
        OFF_FLAGS: ; // flags ignore writes
        OFF_DATA: if (st_r.wlane0) begin
          s.tx_hold = st_r.wdata;
          // without a prior status read the byte sits unsent
          if (st_r.tx_arm) begin
            s.tx_empty_flag = 1'b0;
            s.tc = 1'b0;
            s.tx_arm = 1'b0;
          end
        end
        default: s.bresp = RESP_SLVERR;
      endcase
    end
    // read channel; side effects happen at the address handshake
    if (st_r.rvalid && s_axi_rready) begin
      s.rvalid = 1'b0;
    end
    if (rd_fire) begin
      s.rvalid = 1'b1;
      s.rresp = RESP_OKAY;
      s.rdata = 8'h00;
      case (rd_addr)
        OFF_BAUD: begin
          s.rdata[B_PRESC +: 2] = st_r.presc;
          s.rdata[B_RATE +: 3] = st_r.rate;
        end
        OFF_CTRL1: begin
          s.rdata[C1_RX9] = st_r.r8;
          s.rdata[C1_TX9] = st_r.t8;
          s.rdata[C1_LEN9] = st_r.len9;
          s.rdata[C1_WAKE] = st_r.wake;
        end
        OFF_CTRL2: begin
          s.rdata = {st_r.tx_empty_irq_en, st_r.tx_done_irq_en, st_r.rx_full_irq_en, st_r.quiet_line_irq_en,
                     st_r.te, st_r.re, st_r.rx_sleep_bit, st_r.break_send};
        end
        OFF_FLAGS: begin
          s.rdata[F_TX_EMPTY_FLAG] = st_r.tx_empty_flag;
          s.rdata[F_TC] = st_r.tc;
          s.rdata[F_RX_FULL_FLAG] = st_r.rx_full_flag;
          s.rdata[F_IDLE] = st_r.idle;
          s.rdata[F_OVR] = st_r.ovr;
          s.rdata[F_NF] = st_r.nf;
          s.rdata[F_FE] = st_r.fe;
          s.snap = {st_r.rx_full_flag, st_r.idle, st_r.ovr, st_r.nf, st_r.fe};
          s.tx_arm = 1'b1;
        end
        OFF_DATA: begin
          s.rdata = st_r.rx_hold;
          // only flags seen at the status read are dropped
          s.rx_full_flag = st_r.rx_full_flag & ~st_r.snap[4];
          s.idle = st_r.idle & ~st_r.snap[3];
          s.ovr = st_r.ovr & ~st_r.snap[2];
          s.nf = st_r.nf & ~st_r.snap[1];
          s.fe = st_r.fe & ~st_r.snap[0];
          s.snap = 5'h00;
        end
        default: s.rresp = RESP_SLVERR;
      endcase
    end
    s.awready = !s.aw_have;
    s.wready = !s.w_have;
    s.arready = !s.rvalid;

    // baud chain; >= copes with a ratio shrunk mid-count
    if (st_r.pcnt >= presc_top) begin
      s.pcnt = 4'h0;
      s.rcnt = (st_r.rcnt >= rate_top) ? 7'h00 : st_r.rcnt + 7'h01;
    end else begin
      s.pcnt = st_r.pcnt + 4'h1;
    end

    // transmitter
    s.te_d = st_r.te;
    if (st_r.te && !st_r.te_d && st_r.tst == TX_IDLE) begin
      s.tst = TX_PRE;
      s.tbit = 4'h0;
      s.tsub = 4'h0;
      s.tc = 1'b0;
    end else if (rt_tick) begin
      unique case (st_r.tst)
        TX_IDLE: if (st_r.te) begin
          if (st_r.break_send) begin
            s.tst = TX_BRK;
            s.tc = 1'b0;
            s.tbit = 4'h0;
            s.tsub = 4'h0;
          end else if (!st_r.tx_empty_flag) begin
            // start bit in bit 0, stop bit last
            s.tshift = {1'b1, st_r.len9 ? st_r.t8 : 1'b1, st_r.tx_hold, 1'b0};
            s.tst = TX_DATA;
            s.tx_empty_flag = 1'b1;
            s.tc = 1'b0;
            s.tbit = 4'h0;
            s.tsub = 4'h0;
          end
        end
        TX_DATA, TX_PRE, TX_BRK: begin
          s.tsub = st_r.tsub + 4'h1;
          if (st_r.tsub == BIT_LAST) begin
            s.tbit = st_r.tbit + 4'h1;
            if (st_r.tst == TX_DATA) begin
              s.tshift = {1'b1, st_r.tshift[10:1]};
            end
            if (st_r.tbit == nbits - 4'h1) begin
              s.tbit = 4'h0;
              // a held break repeats frame after frame
              if (st_r.tst == TX_BRK && st_r.break_send) begin
                s.tst = TX_BRK;
              end else begin
                s.tst = TX_IDLE;
                if (st_r.tx_empty_flag) begin
                  s.tc = 1'b1;
                end
              end
            end
          end
        end
      endcase
    end
    s.txd = (s.tst == TX_DATA) ? s.tshift[0] : (s.tst != TX_BRK);
    s.txd_oe = s.te || (s.tst != TX_IDLE);

    // receiver
    if (!st_r.re) begin
      s.rxs = RX_IDLE;
      s.rsub = 4'h0;
      s.ilc = 8'h00;
    end else if (rt_tick) begin
      unique case (st_r.rxs)
        RX_IDLE: begin
          if (!rxd) begin
            s.rxs = RX_START;
            s.rsub = 4'h0;
            s.rnoise = 1'b0;
            s.ilc = 8'h00;
          end else if (st_r.ilc != idle_top) begin
            s.ilc = st_r.ilc + 8'h01;
            idle_hit = (st_r.ilc == idle_top - 8'h01);
          end
        end
        RX_START, RX_BITS: begin
          s.rsub = st_r.rsub + 4'h1;
          if (st_r.rsub == SAMPLE_A) s.smp[0] = rxd;
          if (st_r.rsub == SAMPLE_B) s.smp[1] = rxd;
          if (st_r.rsub == SAMPLE_C) s.smp[2] = rxd;
          if (st_r.rsub == BIT_LAST) begin
            s.rnoise = st_r.rnoise | nz;
            if (st_r.rxs == RX_START) begin
              // a start that votes high was a glitch
              s.rxs = maj ? RX_IDLE : RX_BITS;
              s.ridx = 4'h0;
            end else if (st_r.ridx < ndata) begin
              s.rshift[st_r.ridx] = maj;
              s.ridx = st_r.ridx + 4'h1;
              if (st_r.ridx == ndata - 4'h1 && maj && st_r.wake && st_r.rx_sleep_bit) begin
                s.rx_sleep_bit = 1'b0;
              end
            end else begin
              s.rxs = RX_IDLE;
              // inhibit uses the old sleep bit so a same-cycle write cannot leak
              if (!st_r.rx_sleep_bit) begin
                if (s.rx_full_flag) begin
                  s.ovr = 1'b1;
                end else if (!s.ovr && !s.fe) begin
                  s.rx_hold = st_r.rshift[7:0];
                  if (st_r.len9) s.r8 = st_r.rshift[8];
                  s.rx_full_flag = 1'b1;
                  s.nf = st_r.rnoise | nz;
                  s.fe = !maj;
                  s.idle_armed = 1'b1;
                end
              end
            end
          end
        end
        default: s.rxs = RX_IDLE;
      endcase
    end
    if (idle_hit) begin
      if (st_r.rx_sleep_bit && !st_r.wake) begin
        s.rx_sleep_bit = 1'b0;
      end else if (!st_r.rx_sleep_bit && st_r.idle_armed) begin
        s.idle = 1'b1;
        s.idle_armed = 1'b0;
      end
    end

    s.irq = (s.tx_empty_irq_en && s.tx_empty_flag) || (s.tx_done_irq_en && s.tc) ||
            (s.rx_full_irq_en && (s.rx_full_flag || s.ovr)) || (s.quiet_line_irq_en && s.idle);

    // holding registers ride through reset untouched
    if (!resetn) begin
      s = '0;
      s.tx_hold = st_r.tx_hold;
      s.rx_hold = st_r.rx_hold;
      s.tx_empty_flag = RST_TX_EMPTY_FLAG;
      s.tc = RST_TC;
      s.idle_armed = RST_IDLE_ARMED;
      s.txd = RST_TXD;
    end
    st_nxt = s;
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = {24'h000000, st_r.rdata};
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign txd = st_r.txd;
  assign txd_oe = st_r.txd_oe;
  assign irq = st_r.irq;

  // checks on the block's own behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_bit16;
    ($changed(st_r.tsub) && st_r.tst != TX_IDLE && $past(st_r.tst) != TX_IDLE)
      |-> $past(rt_tick);
  endproperty
  a_bit16: assert property (p_bit16) else $error("tx bit phase moved without tick");
  property p_presc13;
    (rt_tick && st_r.presc == 2'h3 && !cfg_wr) |=> !rt_tick;
  endproperty
  a_presc13: assert property (p_presc13) else $error("prescale 13 ticked too soon");
  property p_rate2;
    (rt_tick && st_r.presc == 2'h0 && st_r.rate == 3'h1 && !cfg_wr) |=> !rt_tick;
  endproperty
  a_rate2: assert property (p_rate2) else $error("rate divide 2 ticked too soon");
  sequence s_load;
    st_r.tst == TX_IDLE ##1 st_r.tst == TX_DATA;
  endsequence
  property p_load;
    s_load |-> st_r.tx_empty_flag && !st_r.tc && !st_r.txd;
  endproperty
  a_load: assert property (p_load) else $error("shifter load flags wrong");
  property p_done;
    (st_r.tc && st_r.tst == TX_IDLE) |-> st_r.txd;
  endproperty
  a_done: assert property (p_done) else $error("line not marking while done");
  property p_brk;
    st_r.tst == TX_BRK |-> !st_r.txd && st_r.txd_oe;
  endproperty
  a_brk: assert property (p_brk) else $error("break not sending zero");
  property p_ovr;
    $rose(st_r.ovr) |-> $past(st_r.rx_full_flag) && $stable(st_r.rx_hold);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without full or data moved");
  property p_nf;
    $rose(st_r.nf) |-> st_r.rx_full_flag;
  endproperty
  a_nf: assert property (p_nf) else $error("noise flag without full flag");
  property p_sleep;
    ($rose(st_r.rx_full_flag) || $rose(st_r.idle)) |-> !$past(st_r.rx_sleep_bit);
  endproperty
  a_sleep: assert property (p_sleep) else $error("rx flag set while asleep");
  property p_irq;
    ((st_r.rx_full_irq_en && (st_r.rx_full_flag || st_r.ovr)) || (st_r.tx_empty_irq_en && st_r.tx_empty_flag)) |-> st_r.irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  property p_rxoff;
    !st_r.re |=> st_r.rxs == RX_IDLE;
  endproperty
  a_rxoff: assert property (p_rxoff) else $error("receiver active while disabled");
endmodule

/* File: tb/asp_far_end.sv */
`timescale 1ns/1ps
// remote serial peer: sends frames on rxd and decodes frames seen on txd
module asp_far_end (
  input wire logic ref_clk,
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic nine,
  input wire logic [15:0] bit_clks,
  output logic rxd,
  output logic [8:0] got,
  output logic [15:0] got_w,
  output logic got_stb
);
  // one frame out; caller enters just after a clock edge
  task automatic send(input logic [8:0] d, input logic n9, input logic stop_lvl);
    logic [10:0] f;
    int nb;
    nb = n9 ? 11 : 10;
    f = n9 ? {stop_lvl, d, 1'b0} : {1'b0, stop_lvl, d[7:0], 1'b0};
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      repeat (bit_clks) @(posedge ref_clk);
    end
    // only a low stop cell needs releasing; back to back frames keep one write per step
    if (!stop_lvl) rxd <= 1'b1;
  endtask

  // receiver: start cell is timed, then each data cell sampled in its middle; the stop cell is not sampled
  initial begin
    int w;
    logic [8:0] d;
    rxd = 1'b1;
    got = '0;
    got_w = '0;
    got_stb = 1'b0;
    forever begin
      @(posedge ref_clk);
      got_stb <= 1'b0;
      if (txd_oe && !txd) begin
        w = 0;
        d = '0;
        // start width only measurable because bench sends odd bytes
        while (!txd && w < 60000) begin
          w++;
          @(posedge ref_clk);
        end
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
          repeat (bit_clks / 2) @(posedge ref_clk);
          d[i] = txd;
          repeat (bit_clks - bit_clks / 2) @(posedge ref_clk);
        end
        repeat (bit_clks / 2) @(posedge ref_clk);
        got <= d;
        got_w <= 16'(w);
        got_stb <= 1'b1;
      end
    end
  end
endmodule

/* File: tb/asp_top_tb_top.sv */
`timescale 1ns/1ps
module asp_top_tb_top
  import asp_pkg::*;
;
  logic ref_clk, resetn;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic rxd, txd, txd_oe, irq, nine9;
  logic [15:0] bclk, got_w;
  logic [8:0] got;
  logic got_stb;
  int n_mismatch, cmp_count;
  logic [33:0] rd_exp[$], rd_msk[$], ser_exp[$];
  int pr[4] = '{1, 3, 4, 13};
  logic [7:0] cfg[7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h05, 8'h12};

  asp_top dut_u (
    .ref_clk(ref_clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .irq(irq)
  );

  asp_far_end far_u (
    .ref_clk(ref_clk), .txd(txd), .txd_oe(txd_oe), .nine(nine9),
    .bit_clks(bclk), .rxd(rxd), .got(got), .got_w(got_w), .got_stb(got_stb)
  );

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a wait that ran out of bound
  task automatic bail();
    n_mismatch++;
    finish_test();
  endtask

  // one write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 1000) bail();
    end while (!(bvalid && bready));
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // one read; the expectation is noted for the watcher
  task automatic rd(input logic [31:0] a, input logic [1:0] r, input logic [7:0] e,
                    input logic [7:0] m);
    int n;
    n = 0;
    rd_exp.push_back({r, 24'h0, e});
    rd_msk.push_back({2'h3, 24'hffffff, m});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 1000) bail();
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask

  // watcher: register answers and decoded serial frames against the notes
  always @(posedge ref_clk) begin
    if (rvalid && rready) begin
      if (rd_exp.size() == 0) begin
        chk(34'h1, 34'h0);
      end else begin
        chk({rresp, rdata} & rd_msk[0], rd_exp[0] & rd_msk[0]);
        void'(rd_exp.pop_front());
        void'(rd_msk.pop_front());
      end
    end
    if (got_stb) begin
      if (ser_exp.size() == 0) begin
        chk(34'h1, 34'h0);
      end else begin
        chk({9'h0, got_w, got}, ser_exp.pop_front());
      end
    end
  end

  // whole run guard
  initial begin
    #400000;
    bail();
  end

  initial begin
    int b, n;
    logic [8:0] d;
    resetn = 1'b0;
    awaddr = '0;
    wdata = '0;
    araddr = '0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    nine9 = 1'b0;
    bclk = 16'd48;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(20));
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // reset values and an unmapped place
    rd(OFF_FLAGS, RESP_OKAY, 8'hc0, 8'hef);
    rd(OFF_CTRL2, RESP_OKAY, 8'h00, 8'hff);
    rd(32'h0000_0020, RESP_SLVERR, 8'h00, 8'hff);
    // transmit across prescale and rate codes; last case in nine-bit frames
    wr(OFF_CTRL2, 8'h08);
    for (int k = 0; k < 7; k++) begin
      wr(OFF_BAUD, cfg[k]);
      b = 16 * pr[cfg[k][5:4]] * (1 << cfg[k][2:0]);
      bclk <= 16'(b);
      if (k == 6) begin
        wr(OFF_CTRL1, 8'h50);
        nine9 <= 1'b1;
      end
      d = {k == 6, 8'($urandom) | 8'h01};
      rd(OFF_FLAGS, RESP_OKAY, 8'h80, 8'h80);
      ser_exp.push_back({9'h0, 16'(b), d});
      wr(OFF_DATA, d[7:0]);
      n = 0;
      while (ser_exp.size() > 0 && n < 50000) begin
        n++;
        @(posedge ref_clk);
      end
      if (ser_exp.size() > 0) bail();
      repeat (2 * b) @(posedge ref_clk);
      rd(OFF_FLAGS, RESP_OKAY, 8'hc0, 8'hc0);
    end
    wr(OFF_CTRL1, 8'h00);
    nine9 <= 1'b0;
    // receive, idle detect, interrupt and read-sequence clearing
    wr(OFF_BAUD, 8'h10);
    bclk <= 16'd48;
    // short break: one frame of zeros, then mark decodes as all ones
    ser_exp.push_back({9'h0, 16'd480, 9'h0ff});
    wr(OFF_CTRL2, 8'h09);
    wr(OFF_CTRL2, 8'h08);
    n = 0;
    while (ser_exp.size() > 0 && n < 50000) begin
      n++;
      @(posedge ref_clk);
    end
    if (ser_exp.size() > 0) bail();
    wr(OFF_CTRL2, 8'h2c);
    far_u.send(9'h05a, 1'b0, 1'b1);
    repeat (12 * 48) @(posedge ref_clk);
    chk({33'h0, irq}, 34'h1);
    rd(OFF_FLAGS, RESP_OKAY, 8'h30, 8'h3e);
    rd(OFF_DATA, RESP_OKAY, 8'h5a, 8'hff);
    repeat (12 * 48) @(posedge ref_clk);
    rd(OFF_FLAGS, RESP_OKAY, 8'h00, 8'h3e);
    chk({33'h0, irq}, 34'h0);
    // second frame while the first is unread
    far_u.send(9'h011, 1'b0, 1'b1);
    far_u.send(9'h022, 1'b0, 1'b1);
    repeat (2 * 48) @(posedge ref_clk);
    rd(OFF_FLAGS, RESP_OKAY, 8'h28, 8'h2e);
    rd(OFF_DATA, RESP_OKAY, 8'h11, 8'hff);
    rd(OFF_FLAGS, RESP_OKAY, 8'h00, 8'h2e);
    // zero where the stop bit belongs
    far_u.send(9'h033, 1'b0, 1'b0);
    repeat (2 * 48) @(posedge ref_clk);
    rd(OFF_FLAGS, RESP_OKAY, 8'h22, 8'h2e);
    rd(OFF_DATA, RESP_OKAY, 8'h33, 8'hff);
    rd(OFF_FLAGS, RESP_OKAY, 8'h00, 8'h2e);
    // address-mark wake-up with nine-bit frames
    wr(OFF_CTRL1, 8'h18);
    wr(OFF_CTRL2, 8'h2e);
    far_u.send(9'h015, 1'b1, 1'b1);
    repeat (2 * 48) @(posedge ref_clk);
    rd(OFF_FLAGS, RESP_OKAY, 8'h00, 8'h2e);
    far_u.send(9'h195, 1'b1, 1'b1);
    repeat (2 * 48) @(posedge ref_clk);
    rd(OFF_CTRL2, RESP_OKAY, 8'h2c, 8'hff);
    rd(OFF_CTRL1, RESP_OKAY, 8'h98, 8'hff);
    rd(OFF_FLAGS, RESP_OKAY, 8'h20, 8'h2e);
    rd(OFF_DATA, RESP_OKAY, 8'h95, 8'hff);
    // receiver disabled: nothing lands
    wr(OFF_CTRL2, 8'h08);
    far_u.send(9'h144, 1'b1, 1'b1);
    repeat (2 * 48) @(posedge ref_clk);
    rd(OFF_FLAGS, RESP_OKAY, 8'h00, 8'h2e);
    finish_test();
  end
endmodule
